// ===== alarm_event_defs.svh
// Register offsets, field positions, reset values and timing counts of the host port.
`ifndef ALARM_EVENT_DEFS_SVH
`define ALARM_EVENT_DEFS_SVH
`define AEI_CTRL_OFF 9'h006
`define AEI_GEV_LO_OFF 9'h00C
`define AEI_GEV_HI_OFF 9'h00D
`define AEI_ACT_OFF 9'h011
`define AEI_SUM_A_OFF 9'h013
`define AEI_SUM_B_OFF 9'h014
`define AEI_GMSK_A_OFF 9'h015
`define AEI_GMSK_B_OFF 9'h016
`define AEI_CH_LEAK_OFF 6'h06
`define AEI_CH_MASK_GRP 4'h2
`define AEI_CH_STAT_GRP 4'h4
`define AEI_CH_EVENT_GRP 4'h5
`define AEI_CH_PERF_GRP 4'h6
`define AEI_CH_FAULT_GRP 4'h7
`define AEI_CTRL_DIS_BIT 7
`define AEI_CTRL_RISE_BIT 6
`define AEI_CTRL_FALL_BIT 5
`define AEI_CTRL_POL_BIT 4
`define AEI_RDI_SUM_BIT 15
`define AEI_CTRL_RST 8'h00
`define AEI_MASK_RST 8'h00
`define AEI_LEAK_RST 8'h00
`define AEI_SYNC_STAGES 2
`define AEI_PIN_IDLE 22'h1C0000
`endif

// ===== alarm_event_pkg.sv
// Types shared by the host port and alarm aggregation logic.
`default_nettype none
package alarm_event_pkg;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACK = 1'b1
  } acc_state_t;
endpackage : alarm_event_pkg
`default_nettype wire

// ===== alarm_event_interrupt_host_port.sv
// Host processor port, per-channel event latching and common interrupt aggregation.
// Operation
// - Events latch and hold until written clear.
// - Onset and removal enable event setting separately.
// - One-second tick captures shadows and counters.
// - Style pin chooses the host bus style.
// - Eight-bit data port released when idle.
// - Separate strobes, or single read/write line.
// - Ready output stretches access until served.
// - Reset clears counters, state and configuration.
// - Global mask bit blocks that condition's interrupt.
// - Summary bit ORs like event of channels.
// - One summary bit covers all remote defects.
// - Activity bit ORs all channel event bits.
// - Disable bit holds interrupt output inactive.
// - Polarity bit inverts interrupt active level.
// - Onset enable sets event on rising status.
// - Removal enable sets event on falling status.
// - Events at global and channel event offsets.
// - New unmasked channel event raises summary, activity, interrupt.
// - Writing zero clears event and derived indications.
// - Per-channel writable pointer leak rate register.
// - Everything runs on the processor clock.
// - Same bit position in mask, event, shadows.
`include "alarm_event_defs.svh"
`default_nettype none
module alarm_event_interrupt_host_port #(
  parameter int NUM_CH = 7,
  parameter int NUM_EV = 19,
  parameter int NUM_GEV = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_bus_style_select,
  input wire logic i_port_select_in_n,
  input wire logic i_write_strobe_in_n,
  input wire logic i_read_strobe_in_n,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_data_in,
  input wire logic i_one_second_tick_in,
  input wire logic [NUM_CH*NUM_EV-1:0] i_chan_status,
  input wire logic [NUM_GEV-1:0] i_global_status,
  output logic [7:0] o_data_out,
  output logic o_data_oe,
  output logic o_access_ready_out,
  output logic o_interrupt_out,
  output logic o_counter_latch,
  output logic [NUM_CH*8-1:0] o_pointer_leak_rate
);

  localparam int PIN_W = 22;

  // Picks one byte lane of a 24-bit group by the low offset bits.
  function automatic logic [7:0] lane_pick(input logic [23:0] v, input logic [1:0] idx);
    lane_pick = (idx == 2'h0) ? v[7:0] : (idx == 2'h1) ? v[15:8] :
                (idx == 2'h2) ? v[23:16] : 8'h00;
  endfunction : lane_pick

  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic tick_prev_q;
  alarm_event_pkg::acc_state_t state_q;
  alarm_event_pkg::acc_state_t state_d;
  logic [7:0] ctrl_q;
  logic [15:0] gmask_q;
  logic [NUM_GEV-1:0] gev_q;
  logic [NUM_GEV-1:0] gst_prev_q;
  logic [7:0] rdata_q;
  logic oe_q;
  logic rdy_q;
  logic irq_q;
  logic latch_q;

  // single processor clock
  // Host pins pass two flip-flops; reset loads idle levels so no access shows at release.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      pin_s1_q <= `AEI_PIN_IDLE;
      pin_s2_q <= `AEI_PIN_IDLE;
    end
    else if (i_ce)
    begin
      pin_s1_q <= {i_bus_style_select, i_port_select_in_n, i_write_strobe_in_n,
                   i_read_strobe_in_n, i_addr, i_data_in, i_one_second_tick_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  wire style_s = pin_s2_q[21];
  wire sel_n_s = pin_s2_q[20];
  wire wr_n_s = pin_s2_q[19];
  wire rd_n_s = pin_s2_q[18];
  wire [8:0] addr_s = pin_s2_q[17:9];
  wire [7:0] din_s = pin_s2_q[8:1];
  wire tick_s = pin_s2_q[0];

  // strobe decoding per style
  // Style 0 uses separate strobes; style 1 uses select plus the read/write line.
  wire acc_now = !sel_n_s && (style_s || !wr_n_s || !rd_n_s);
  wire acc_wr = style_s ? !rd_n_s : !wr_n_s;
  wire acc_start = acc_now && (state_q == alarm_event_pkg::ST_IDLE);
  wire wr_pulse = acc_start && acc_wr;

  wire tick_rise = tick_s && !tick_prev_q;

  // Register hits in the common area.
  wire hit_ctrl = (addr_s == `AEI_CTRL_OFF);
  wire hit_gev_lo = (addr_s == `AEI_GEV_LO_OFF);
  wire hit_gev_hi = (addr_s == `AEI_GEV_HI_OFF);
  wire hit_act = (addr_s == `AEI_ACT_OFF);
  wire hit_sum_a = (addr_s == `AEI_SUM_A_OFF);
  wire hit_sum_b = (addr_s == `AEI_SUM_B_OFF);
  wire hit_gmsk_a = (addr_s == `AEI_GMSK_A_OFF);
  wire hit_gmsk_b = (addr_s == `AEI_GMSK_B_OFF);

  wire rise_en = ctrl_q[`AEI_CTRL_RISE_BIT];
  wire fall_en = ctrl_q[`AEI_CTRL_FALL_BIT];

  // Per-channel results gathered for the common registers.
  logic [18:0] ev_q [NUM_CH];
  logic [18:0] st_prev_q [NUM_CH];
  logic [NUM_CH*NUM_EV-1:0] ev_flat;
  logic [NUM_CH*NUM_EV-1:0] perf_flat;
  logic [NUM_CH*NUM_EV-1:0] fault_flat;
  logic [NUM_CH*NUM_EV-1:0] prev_flat;
  logic [15:0] sum_chain [NUM_CH+1];
  logic [15:0] unm_chain [NUM_CH+1];
  logic [7:0] rd_chain [NUM_CH+1];
  logic [NUM_CH-1:0] activity;

  assign sum_chain[0] = 16'h0000;
  assign unm_chain[0] = 16'h0000;
  assign rd_chain[0] = 8'h00;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ch
      logic [18:0] mask_q;
      logic [18:0] perf_q;
      logic [18:0] fault_q;
      logic [7:0] leak_q;
      wire [18:0] st = i_chan_status[c*NUM_EV +: NUM_EV];
      wire hit = (addr_s[8:6] == 3'(c + 1));
      wire [5:0] off = addr_s[5:0];
      wire [3:0] grp = off[5:2];
      wire wr_ev = wr_pulse && hit && (grp == `AEI_CH_EVENT_GRP);
      wire wr_mask = wr_pulse && hit && (grp == `AEI_CH_MASK_GRP);
      wire wr_leak = wr_pulse && hit && (off == `AEI_CH_LEAK_OFF);
      wire [18:0] ev_set = ({19{rise_en}} & st & ~st_prev_q[c]) |
                           ({19{fall_en}} & ~st & st_prev_q[c]);
      // zero bits clear
      // Written zeros clear the addressed lane, ones keep it.
      wire [23:0] keep = {(wr_ev && off[1:0] == 2'h2) ? din_s : 8'hFF,
                          (wr_ev && off[1:0] == 2'h1) ? din_s : 8'hFF,
                          (wr_ev && off[1:0] == 2'h0) ? din_s : 8'hFF};
      wire [23:0] mask24 = {5'h00, mask_q};
      wire [23:0] mask_wr = {(wr_mask && off[1:0] == 2'h2) ? din_s : mask24[23:16],
                             (wr_mask && off[1:0] == 2'h1) ? din_s : mask24[15:8],
                             (wr_mask && off[1:0] == 2'h0) ? din_s : mask24[7:0]};
      wire [18:0] ev_d = (ev_q[c] & keep[18:0]) | ev_set;
      wire [15:0] fold = ev_q[c][15:0] |
                         (16'(|ev_q[c][18:16]) << `AEI_RDI_SUM_BIT);
      wire [18:0] unm = ev_q[c] & ~mask_q;
      wire [15:0] unm_fold = unm[15:0] | (16'(|unm[18:16]) << `AEI_RDI_SUM_BIT);
      wire [7:0] rd_byte =
        (off == `AEI_CH_LEAK_OFF) ? leak_q :
        (grp == `AEI_CH_MASK_GRP) ? lane_pick({5'h00, mask_q}, off[1:0]) :
        (grp == `AEI_CH_STAT_GRP) ? lane_pick({5'h00, st}, off[1:0]) :
        (grp == `AEI_CH_EVENT_GRP) ? lane_pick({5'h00, ev_q[c]}, off[1:0]) :
        (grp == `AEI_CH_PERF_GRP) ? lane_pick({5'h00, perf_q}, off[1:0]) :
        (grp == `AEI_CH_FAULT_GRP) ? lane_pick({5'h00, fault_q}, off[1:0]) : 8'h00;

      // channel event registers
      // Event, mask and previous-status registers of one channel.
      always_ff @(posedge i_clk_sys)
      begin
        if (i_rst)
        begin
          ev_q[c] <= '0;
          st_prev_q[c] <= '0;
          mask_q <= '0;
          leak_q <= `AEI_LEAK_RST;
        end
        else if (i_ce)
        begin
          ev_q[c] <= ev_d;
          st_prev_q[c] <= st;
          mask_q <= mask_wr[18:0];
          if (wr_leak)
            leak_q <= din_s;
        end
      end

      // shadow capture
      // Performance keeps the latched events, fault keeps the live status.
      always_ff @(posedge i_clk_sys)
      begin
        if (i_rst)
        begin
          perf_q <= '0;
          fault_q <= '0;
        end
        else if (i_ce && tick_rise)
        begin
          perf_q <= ev_q[c];
          fault_q <= st;
        end
      end

      assign ev_flat[c*NUM_EV +: NUM_EV] = ev_q[c];
      assign prev_flat[c*NUM_EV +: NUM_EV] = st_prev_q[c];
      assign perf_flat[c*NUM_EV +: NUM_EV] = perf_q;
      assign fault_flat[c*NUM_EV +: NUM_EV] = fault_q;
      assign o_pointer_leak_rate[c*8 +: 8] = leak_q;
      assign activity[c] = |ev_q[c];
      assign sum_chain[c+1] = sum_chain[c] | fold;
      assign unm_chain[c+1] = unm_chain[c] | unm_fold;
      assign rd_chain[c+1] = rd_chain[c] | (hit ? rd_byte : 8'h00);
    end
  endgenerate

  wire [15:0] summary = sum_chain[NUM_CH];
  wire irq_any = |(unm_chain[NUM_CH] & ~gmask_q);
  wire irq_d = ctrl_q[`AEI_CTRL_POL_BIT] ^ (!ctrl_q[`AEI_CTRL_DIS_BIT] && irq_any);

  // Common-area events use the same onset and removal enables.
  wire [NUM_GEV-1:0] gev_set = ({NUM_GEV{rise_en}} & i_global_status & ~gst_prev_q) |
                               ({NUM_GEV{fall_en}} & ~i_global_status & gst_prev_q);
  wire [15:0] gkeep = {(wr_pulse && hit_gev_hi) ? din_s : 8'hFF,
                       (wr_pulse && hit_gev_lo) ? din_s : 8'hFF};

  // Read data selection over the whole map; unmapped offsets read zero.
  wire [7:0] rd_mux =
    hit_ctrl ? ctrl_q :
    hit_gev_lo ? gev_q[7:0] :
    hit_gev_hi ? gev_q[15:8] :
    hit_act ? {1'b0, activity} :
    hit_sum_a ? summary[7:0] :
    hit_sum_b ? summary[15:8] :
    hit_gmsk_a ? gmask_q[7:0] :
    hit_gmsk_b ? gmask_q[15:8] : rd_chain[NUM_CH];

  // global event registers
  // Common control, global masks and common events.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      ctrl_q <= `AEI_CTRL_RST;
      gmask_q <= {`AEI_MASK_RST, `AEI_MASK_RST};
      gev_q <= '0;
      gst_prev_q <= '0;
      tick_prev_q <= 1'b0;
    end
    else if (i_ce)
    begin
      gev_q <= (gev_q & gkeep) | gev_set;
      gst_prev_q <= i_global_status;
      tick_prev_q <= tick_s;
      if (wr_pulse && hit_ctrl)
        ctrl_q <= din_s;
      if (wr_pulse && hit_gmsk_a)
        gmask_q[7:0] <= din_s;
      if (wr_pulse && hit_gmsk_b)
        gmask_q[15:8] <= din_s;
    end
  end

  // ready when served
  // An access is served on its first synchronised cycle and held until released.
  assign state_d = acc_now ? alarm_event_pkg::ST_ACK : alarm_event_pkg::ST_IDLE;

  // drive only during reads
  // Port state, read data, ready, interrupt and counter latch outputs.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state_q <= alarm_event_pkg::ST_IDLE;
      rdata_q <= 8'h00;
      oe_q <= 1'b0;
      rdy_q <= 1'b0;
      irq_q <= 1'b0;
      latch_q <= 1'b0;
    end
    else if (i_ce)
    begin
      state_q <= state_d;
      if (acc_start)
        rdata_q <= rd_mux;
      oe_q <= acc_now && !acc_wr;
      rdy_q <= acc_now;
      irq_q <= irq_d;
      latch_q <= tick_rise;
    end
  end

  assign o_data_out = rdata_q;
  assign o_data_oe = oe_q;
  assign o_access_ready_out = rdy_q;
  assign o_interrupt_out = irq_q;
  assign o_counter_latch = latch_q;

  // Checks on the aggregation and port behaviour.
  property p_irq_off;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && ctrl_q[`AEI_CTRL_DIS_BIT]) |=> (o_interrupt_out == $past(ctrl_q[4]));
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt active while disabled");

  property p_irq_pol;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && !ctrl_q[`AEI_CTRL_DIS_BIT] && irq_any) |=> (o_interrupt_out != $past(ctrl_q[4]));
  endproperty
  a_irq_pol: assert property (p_irq_pol) else $error("interrupt level wrong");

  property p_mask_block;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && ((unm_chain[NUM_CH] & ~gmask_q) == 16'h0000)) |=> (o_interrupt_out == $past(ctrl_q[4]));
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked event interrupted");

  property p_onset;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && rise_en) |=> ((ev_flat & $past(i_chan_status & ~prev_flat)) ==
                           $past(i_chan_status & ~prev_flat));
  endproperty
  a_onset: assert property (p_onset) else $error("onset did not set event");

  property p_removal;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && fall_en) |=> ((ev_flat & $past(~i_chan_status & prev_flat)) ==
                           $past(~i_chan_status & prev_flat));
  endproperty
  a_removal: assert property (p_removal) else $error("removal did not set event");

  property p_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && !wr_pulse) |=> ((ev_flat & $past(ev_flat)) == $past(ev_flat));
  endproperty
  a_hold: assert property (p_hold) else $error("event lost without write");

  property p_idle_release;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && !acc_now) |=> !o_data_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("data driven when idle");

  property p_ready;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && acc_start) |=> (o_access_ready_out && state_q == alarm_event_pkg::ST_ACK);
  endproperty
  a_ready: assert property (p_ready) else $error("access not acknowledged");

  property p_capture;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && tick_rise) |=> (perf_flat == $past(ev_flat) && fault_flat == $past(i_chan_status)
                             && o_counter_latch);
  endproperty
  a_capture: assert property (p_capture) else $error("shadow capture missed");

endmodule : alarm_event_interrupt_host_port
`default_nettype wire

// ===== host_bus_model.sv
// Host processor model that drives the register port pins of the block.
`default_nettype none
module host_bus_model (
  input wire logic i_clk_sys,
  input wire logic i_style,
  input wire logic i_ready,
  input wire logic [7:0] i_rdata,
  input wire logic i_oe,
  output logic o_sel_n,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic [8:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] stalls;
  logic oe_at_ack;

  // Idle pins at time zero.
  initial
  begin
    stalls = 8'h00;
    oe_at_ack = 1'b0;
    o_sel_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_addr = 9'h000;
    o_wdata = 8'h00;
  end

  task automatic access(input logic wr, input logic [8:0] a, input logic [7:0] wd,
    output logic [7:0] rd);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    o_addr = a;
    o_wdata = wr ? wd : o_wdata;
    o_sel_n = 1'b0;
    o_wr_n = i_style | ~wr;
    o_rd_n = i_style ? ~wr : wr;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end while (i_ready !== 1'b1 && n < 20);
    // An access that never sees ready counts as a stall.
    if (i_ready !== 1'b1)
      stalls = stalls + 8'h01;
    rd = i_rdata;
    oe_at_ack = i_oe;
    @(negedge i_clk_sys);
    o_sel_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    // A released data line must not keep showing the last value.
    o_wdata = ~o_wdata;
    o_addr = ~a;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end while (i_ready !== 1'b0 && n < 40);
    if (n >= 40)
      stalls = stalls + 8'h01;
    @(negedge i_clk_sys);
  endtask : access
endmodule : host_bus_model
`default_nettype wire

// ===== alarm_event_interrupt_host_port_tb_top.sv
// Self-checking bench for the host port and interrupt aggregation.
`include "alarm_event_defs.svh"
`default_nettype none
module alarm_event_interrupt_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic style = 1'b0;
  logic tick = 1'b0;
  logic ce = 1'b1;
  logic [132:0] st = '0;
  logic [15:0] gst = '0;
  logic sel_n, wr_n, rd_n, oe, rdy, irq, latch;
  logic [8:0] addr;
  logic [7:0] wd, rdat;
  logic [55:0] leak;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic seen;

  alarm_event_interrupt_host_port i_alarm_event_interrupt_host_port (
    .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_bus_style_select(style),
    .i_port_select_in_n(sel_n), .i_write_strobe_in_n(wr_n), .i_read_strobe_in_n(rd_n),
    .i_addr(addr), .i_data_in(wd), .i_one_second_tick_in(tick), .i_chan_status(st),
    .i_global_status(gst), .o_data_out(rdat), .o_data_oe(oe), .o_access_ready_out(rdy),
    .o_interrupt_out(irq), .o_counter_latch(latch), .o_pointer_leak_rate(leak));

  host_bus_model i_host_bus_model (
    .i_clk_sys(clk), .i_style(style), .i_ready(rdy), .i_rdata(rdat), .i_oe(oe), .o_sel_n(sel_n),
    .o_wr_n(wr_n), .o_rd_n(rd_n), .o_addr(addr), .o_wdata(wd));

  // Clock of 50 ns period.
  initial
  begin
    forever #25 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host_bus_model.access(1'b0, a, 8'h00, v);
    chk($sformatf("reg %h", a), e, v);
    chk("oe read", 8'h01, {7'h00, i_host_bus_model.oe_at_ack});
    chk("oe idle", 8'h00, {7'h00, oe});
  endtask : rd

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] v;
    i_host_bus_model.access(1'b1, a, d, v);
    chk("oe write", 8'h00, {7'h00, i_host_bus_model.oe_at_ack});
  endtask : wr

  task automatic pause();
    repeat (3) @(negedge clk);
  endtask : pause

  // Main test sequence.
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    pause();
    rd(`AEI_CTRL_OFF, 8'h00);
    rd(`AEI_GMSK_A_OFF, 8'h00);
    rd(9'h003, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    wr(9'h086, 8'h5A);
    chk("leak", 8'h5A, leak[15:8]);
    rd(9'h086, 8'h5A);
    $display("test reset and leak done");
    wr(`AEI_CTRL_OFF, 8'h60);
    st[24] = 1'b1;
    pause();
    chk("irq", 8'h01, {7'h00, irq});
    rd(9'h094, 8'h20);
    rd(`AEI_ACT_OFF, 8'h02);
    rd(`AEI_SUM_A_OFF, 8'h20);
    rd(9'h094, 8'h20);
    wr(9'h094, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    rd(`AEI_SUM_A_OFF, 8'h00);
    rd(`AEI_ACT_OFF, 8'h00);
    st[24] = 1'b0;
    pause();
    rd(9'h094, 8'h20);
    $display("test edges done");
    tick = 1'b1;
    seen = 1'b0;
    repeat (6)
    begin
      @(negedge clk);
      seen = seen | latch;
    end
    tick = 1'b0;
    chk("latch", 8'h01, {7'h00, seen});
    rd(9'h098, 8'h20);
    rd(9'h09C, 8'h00);
    $display("test tick done");
    wr(9'h094, 8'h00);
    wr(`AEI_GMSK_A_OFF, 8'h20);
    st[24] = 1'b1;
    pause();
    chk("irq", 8'h00, {7'h00, irq});
    rd(`AEI_ACT_OFF, 8'h02);
    wr(`AEI_GMSK_A_OFF, 8'h00);
    chk("irq", 8'h01, {7'h00, irq});
    wr(`AEI_CTRL_OFF, 8'h70);
    chk("irq", 8'h00, {7'h00, irq});
    wr(`AEI_CTRL_OFF, 8'hF0);
    chk("irq", 8'h01, {7'h00, irq});
    wr(`AEI_CTRL_OFF, 8'hC0);
    chk("irq", 8'h00, {7'h00, irq});
    wr(9'h094, 8'h00);
    wr(`AEI_CTRL_OFF, 8'h40);
    st[24] = 1'b0;
    pause();
    rd(9'h094, 8'h00);
    $display("test mask and level done");
    st[131] = 1'b1;
    gst[0] = 1'b1;
    pause();
    rd(`AEI_SUM_B_OFF, 8'h80);
    rd(9'h1D6, 8'h02);
    rd(`AEI_ACT_OFF, 8'h40);
    rd(`AEI_GEV_LO_OFF, 8'h01);
    style = 1'b1;
    pause();
    wr(9'h1C6, 8'hA5);
    rd(9'h1C6, 8'hA5);
    chk("leak", 8'hA5, leak[55:48]);
    $display("test summary and style done");
    ce = 1'b0;
    tick = 1'b1;
    seen = 1'b0;
    repeat (6)
    begin
      @(negedge clk);
      seen = seen | latch;
    end
    tick = 1'b0;
    ce = 1'b1;
    pause();
    seen = seen | latch;
    chk("frozen latch", 8'h00, {7'h00, seen});
    $display("test clock enable done");
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    pause();
    chk("leak", 8'h00, leak[55:48]);
    rd(`AEI_CTRL_OFF, 8'h00);
    rd(`AEI_ACT_OFF, 8'h00);
    chk("stalls", 8'h00, i_host_bus_model.stalls);
    $display("test reset again done");
    test_done();
  end
endmodule : alarm_event_interrupt_host_port_tb_top
`default_nettype wire
